// ==== bbc_host.sv ====
// Register-port host model: one-cycle write and read strobes.
// Assumes the bank samples strobes on the rising edge of clk_sys.
module bbc_host (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle values at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Strobe held for one sampling edge; bus scrambled after release so stale data is not reused
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

// ==== bbc_pkg.sv ====
// Constants for the billboard configuration register bank.
// Assumes an 8-bit register port in the hub core clock domain.
package bbc_pkg;
  localparam logic [7:0] BBC_OFS_CONFIG = 8'h2B;
  localparam logic [7:0] BBC_OFS_STR1_LEN = 8'h2C;
  localparam logic [7:0] BBC_OFS_STR2_LEN = 8'h2D;
  localparam logic [7:0] BBC_RST_STR_LEN = 8'h2C;
  localparam logic [3:0] BBC_RST_CONN_PWR = 4'h0;
  localparam logic [3:0] BBC_I2C_CONN_PWR = 4'h8;
  localparam int BBC_POS_CONN_PWR = 4;
  localparam int BBC_POS_RESULT = 2;
  localparam int BBC_POS_FAIL = 1;
  localparam int BBC_POS_CONN = 0;
  localparam int BBC_POS_NOPWR = 3;
  localparam logic [1:0] BBC_RES_ERROR = 2'h0;
  localparam logic [1:0] BBC_RES_NOT_TRIED = 2'h1;
  localparam logic [1:0] BBC_RES_FAILED = 2'h2;
  localparam logic [1:0] BBC_RES_OK = 2'h3;
  localparam logic [9:0] BBC_STR_BYTE_LIMIT = 10'h1E0;
endpackage

// ==== bbc_regs.sv ====
// Billboard configuration register bank with descriptor field outputs.
// Assumes a single-cycle byte register port on clk_sys; straps come from pins.
module bbc_regs
  import bbc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Mode select: high for I2C (EEPROM) mode, low for SMBus mode
  input wire logic i2c_mode,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Strap pins
  input wire logic [1:0] alt_mode_result_strap,
  input wire logic billboard_enable_strap,
  // Descriptor fields
  output logic [1:0] descriptor_config_result,
  output logic [7:0] descriptor_extra_failure_info,
  output logic [3:0] connector_power_field,
  output logic no_connector_power,
  output logic billboard_connected_flag,
  output logic [7:0] first_string_char_count,
  output logic [7:0] second_string_char_count,
  output logic [8:0] first_desc_length,
  output logic [8:0] second_desc_length,
  output logic [9:0] second_string_offset,
  output logic string_size_ok
);

  logic [1:0] strap_res_s1_ff, strap_res_ff;
  logic strap_en_s1_ff, strap_en_ff;
  logic [3:0] conn_pwr_ff;
  logic [1:0] alt_mode_result_ff;
  logic extra_failure_bit_ff;
  logic conn_flag_ff;
  logic [7:0] str1_len_ff, str2_len_ff;
  logic [7:0] nxt_rdata;
  logic [3:0] eff_pwr;
  logic [1:0] eff_res;
  logic eff_fail, eff_conn;
  logic [9:0] str1_bytes, str2_bytes;

  // Two-stage synchronisers for strap pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_res_s1_ff <= 2'h0;
      strap_res_ff <= 2'h0;
      strap_en_s1_ff <= 1'b0;
      strap_en_ff <= 1'b0;
    end else begin
      strap_res_s1_ff <= alt_mode_result_strap;
      strap_res_ff <= strap_res_s1_ff;
      strap_en_s1_ff <= billboard_enable_strap;
      strap_en_ff <= strap_en_s1_ff;
    end
  end

  // Configuration byte writes; in I2C mode the stored bits are kept but masked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conn_pwr_ff <= BBC_RST_CONN_PWR;
      alt_mode_result_ff <= BBC_RES_ERROR;
      extra_failure_bit_ff <= 1'b0;
      conn_flag_ff <= 1'b0;
    end else if (reg_wr && reg_addr == BBC_OFS_CONFIG && !i2c_mode) begin
      conn_pwr_ff <= reg_wdata[BBC_POS_CONN_PWR +: 4];
      alt_mode_result_ff <= reg_wdata[BBC_POS_RESULT +: 2];
      extra_failure_bit_ff <= reg_wdata[BBC_POS_FAIL];
      conn_flag_ff <= reg_wdata[BBC_POS_CONN];
    end
  end

  // String length registers, writable in both modes (EEPROM load or host)
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      str1_len_ff <= BBC_RST_STR_LEN;
      str2_len_ff <= BBC_RST_STR_LEN;
    end else if (reg_wr) begin
      if (reg_addr == BBC_OFS_STR1_LEN) str1_len_ff <= reg_wdata;
      if (reg_addr == BBC_OFS_STR2_LEN) str2_len_ff <= reg_wdata;
    end
  end

  // Effective field values per mode
  always_comb begin
    eff_pwr = i2c_mode ? BBC_I2C_CONN_PWR : conn_pwr_ff;
    eff_res = i2c_mode ? strap_res_ff : alt_mode_result_ff;
    eff_fail = i2c_mode ? 1'b0 : extra_failure_bit_ff;
    eff_conn = i2c_mode ? strap_en_ff : conn_flag_ff;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (reg_addr)
      BBC_OFS_CONFIG: nxt_rdata = {eff_pwr, eff_res, eff_fail, eff_conn};
      BBC_OFS_STR1_LEN: nxt_rdata = str1_len_ff;
      BBC_OFS_STR2_LEN: nxt_rdata = str2_len_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Registered read data, held between reads
  always_ff @(posedge clk_sys) begin
    if (rst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= nxt_rdata;
  end

  // String sizing; byte counts of the UTF-16 bodies
  assign str1_bytes = {1'b0, str1_len_ff, 1'b0};
  assign str2_bytes = {1'b0, str2_len_ff, 1'b0};

  // Descriptor outputs registered so they change one cycle after the cause
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      descriptor_config_result <= BBC_RES_ERROR;
      descriptor_extra_failure_info <= 8'h00;
      connector_power_field <= BBC_RST_CONN_PWR;
      no_connector_power <= 1'b0;
      billboard_connected_flag <= 1'b0;
      first_string_char_count <= BBC_RST_STR_LEN;
      second_string_char_count <= BBC_RST_STR_LEN;
      // Lengths reset to what the reset counts imply, so the length outputs never disagree with them
      first_desc_length <= 9'({1'b0, BBC_RST_STR_LEN, 1'b0} + 10'h002);
      second_desc_length <= 9'({1'b0, BBC_RST_STR_LEN, 1'b0} + 10'h002);
      second_string_offset <= 10'(({1'b0, BBC_RST_STR_LEN, 1'b0} + 10'h003) & 10'h3FC);
      string_size_ok <= 1'b0;
    end else begin
      descriptor_config_result <= eff_res;
      // Failure info only meaningful when connector power is required
      descriptor_extra_failure_info <= {7'h00, eff_fail & ~eff_pwr[BBC_POS_NOPWR]};
      connector_power_field <= eff_pwr;
      no_connector_power <= eff_pwr[BBC_POS_NOPWR];
      billboard_connected_flag <= eff_conn;
      first_string_char_count <= str1_len_ff;
      second_string_char_count <= str2_len_ff;
      first_desc_length <= 9'(str1_bytes + 10'h002);
      second_desc_length <= 9'(str2_bytes + 10'h002);
      // Round up to a 4-byte boundary directly after string one
      second_string_offset <= 10'((str1_bytes + 10'h003) & 10'h3FC);
      // Advisory check of the host's sizing duty; an odd string-one count costs the pad bytes
      string_size_ok <= (11'(str1_bytes) + 11'(str2_bytes) + 11'({str1_len_ff[0], 1'b0}))
                        <= 11'(BBC_STR_BYTE_LIMIT);
    end
  end

  // Assertions
  // Steps shared by the mode-dependent properties; a mode flip inside a check
  // would compare against the other mode's source, so both ends must agree
  sequence s_i2c_steady;
    i2c_mode ##1 i2c_mode;
  endsequence
  sequence s_cfg_wr_smb;
    reg_wr && reg_addr == BBC_OFS_CONFIG && !i2c_mode;
  endsequence
  sequence s_cfg_wr_i2c;
    reg_wr && reg_addr == BBC_OFS_CONFIG && i2c_mode;
  endsequence
  sequence s_smb_cfg_update;
    s_cfg_wr_smb ##1 !i2c_mode;
  endsequence

  // Failure info drops whenever the effective power field says no power is needed
  a_fail_masked_pwr: assert property (@(posedge clk_sys) disable iff (rst)
    $past(eff_pwr[BBC_POS_NOPWR]) |-> descriptor_extra_failure_info == 8'h00)
    else $error("failure info not masked");

  // Power field pinned in I2C mode, one register stage behind the mode input
  a_i2c_pwr_fixed: assert property (@(posedge clk_sys) disable iff (rst)
    i2c_mode |=> connector_power_field == BBC_I2C_CONN_PWR)
    else $error("i2c power field wrong");

  // Failure info forced low while the bank stays in I2C mode
  a_i2c_fail_zero: assert property (@(posedge clk_sys) disable iff (rst)
    s_i2c_steady |-> descriptor_extra_failure_info == 8'h00)
    else $error("i2c failure bit not zero");

  // Result code tracks the synchronised strap pins in I2C mode
  a_i2c_res_strap: assert property (@(posedge clk_sys) disable iff (rst)
    s_i2c_steady |-> descriptor_config_result == $past(strap_res_ff))
    else $error("result does not follow strap");

  // Config writes in I2C mode leave every stored field untouched
  a_i2c_cfg_kept: assert property (@(posedge clk_sys) disable iff (rst)
    s_cfg_wr_i2c |=> $stable(alt_mode_result_ff) && $stable(extra_failure_bit_ff)
      && $stable(conn_pwr_ff) && $stable(conn_flag_ff))
    else $error("i2c config write not ignored");

  // Written result code reaches the descriptor two edges after the write
  a_smb_res_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_smb_cfg_update |=>
      descriptor_config_result == $past(reg_wdata[BBC_POS_RESULT +: 2], 2))
    else $error("result not taken from write");

  // Written failure bit reaches the descriptor unless the same write claims no power
  a_smb_fail_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_smb_cfg_update |=> descriptor_extra_failure_info == 8'($past(reg_wdata[BBC_POS_FAIL], 2)
      && !$past(reg_wdata[BBC_POS_CONN_PWR + BBC_POS_NOPWR], 2)))
    else $error("failure bit not taken from write");

  // Connected flag tracks the synchronised enable strap in I2C mode
  a_conn_strap: assert property (@(posedge clk_sys) disable iff (rst)
    s_i2c_steady |-> billboard_connected_flag == $past(strap_en_ff))
    else $error("connected flag not following strap");

  // Length writes land at the next edge in either mode
  a_str1_write: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == BBC_OFS_STR1_LEN |=> str1_len_ff == $past(reg_wdata))
    else $error("string one length not written");

  a_str2_write: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == BBC_OFS_STR2_LEN |=> str2_len_ff == $past(reg_wdata))
    else $error("string two length not written");

  // Descriptor lengths are byte counts: two bytes per UTF-16 character plus two
  a_str1_len: assert property (@(posedge clk_sys) disable iff (rst)
    first_desc_length == 9'({$past(str1_len_ff), 1'b0} + 10'h002))
    else $error("first descriptor length wrong");

  a_str2_len: assert property (@(posedge clk_sys) disable iff (rst)
    second_desc_length == 9'({$past(str2_len_ff), 1'b0} + 10'h002))
    else $error("second descriptor length wrong");

  // String two starts on the first 4-byte boundary at or after the end of string one
  a_str2_align: assert property (@(posedge clk_sys) disable iff (rst)
    second_string_offset[1:0] == 2'h0 && second_string_offset >= $past(str1_bytes)
      && second_string_offset < 10'($past(str1_bytes) + 10'h004))
    else $error("second string misplaced");

  // No-power flag is the top bit of the reported power field
  a_nopwr_flag: assert property (@(posedge clk_sys) disable iff (rst)
    no_connector_power == connector_power_field[BBC_POS_NOPWR])
    else $error("no power flag mismatch");
endmodule

// ==== bbc_regs_tb.sv ====
// Self-checking bench for the billboard configuration register bank.
// Assumes the bbc_host model drives the register port.
module bbc_regs_tb
  import bbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic i2c_mode = 1'b0;
  logic [1:0] strap_res = 2'h0;
  logic strap_en = 1'b0;
  logic reg_wr, reg_rd, rd_seen = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fail_info, s1_cnt, s2_cnt, v, s1, s2;
  logic [1:0] cfg_res;
  logic [3:0] pwr;
  logic no_pwr, conn;
  logic [8:0] len1, len2;
  logic [9:0] ofs2;
  logic size_ok;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int checks_done = 0;
  int t;
  always #5 clk_sys = ~clk_sys;
  bbc_host host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  bbc_regs DUT (.clk_sys(clk_sys), .rst(rst), .i2c_mode(i2c_mode), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .alt_mode_result_strap(strap_res), .billboard_enable_strap(strap_en),
    .descriptor_config_result(cfg_res), .descriptor_extra_failure_info(fail_info),
    .connector_power_field(pwr), .no_connector_power(no_pwr),
    .billboard_connected_flag(conn), .first_string_char_count(s1_cnt),
    .second_string_char_count(s2_cnt), .first_desc_length(len1), .second_desc_length(len2),
    .second_string_offset(ofs2), .string_size_ok(size_ok));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Note the expected byte, then issue the read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Read data lands one edge after the strobe edge; an empty queue is itself a fault
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) check(10'(reg_rdata), 10'h3FF);
      else check(10'(reg_rdata), 10'(exp_q.pop_front()));
    end
    rd_seen <= reg_rd;
  end
  initial begin
    void'($urandom(32'hFB9E));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(BBC_OFS_CONFIG, 8'h00);
    rd(BBC_OFS_STR1_LEN, BBC_RST_STR_LEN);
    rd(BBC_OFS_STR2_LEN, BBC_RST_STR_LEN);
    rd(8'h2E, 8'h00);
    // SMBus mode: every result code, failure bit against both power top-bit values
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[3:2] = i[1:0];
      v[1] = i[0];
      v[7] = i[2];
      host.xfer(1'b1, BBC_OFS_CONFIG, v);
      rd(BBC_OFS_CONFIG, v);
      repeat (2) @(posedge clk_sys);
      #1;
      check(10'(cfg_res), 10'(v[3:2]));
      check(10'(fail_info), 10'(v[1] & ~v[7]));
      check(10'({pwr, no_pwr}), 10'({v[7:4], v[7]}));
      check(10'(conn), 10'(v[0]));
    end
    // Length pairs: exact limit, one past it, then random legal sizes
    for (int i = 0; i < 5; i++) begin
      s1 = (i == 0) ? 8'd120 : (i == 1) ? 8'd121 : 8'($urandom_range(0, 120));
      s2 = (i == 0) ? 8'd120 : (i == 1) ? 8'd119 : 8'($urandom_range(0, 118));
      host.xfer(1'b1, BBC_OFS_STR1_LEN, s1);
      host.xfer(1'b1, BBC_OFS_STR2_LEN, s2);
      rd(BBC_OFS_STR1_LEN, s1);
      rd(BBC_OFS_STR2_LEN, s2);
      #1;
      t = 2 * int'(s1) + 2 * int'(s2) + (s1[0] ? 2 : 0);
      check(10'(s1_cnt), 10'(s1));
      check(10'(s2_cnt), 10'(s2));
      check(10'(len1), 10'(2 + 2 * int'(s1)));
      check(10'(len2), 10'(2 + 2 * int'(s2)));
      check(ofs2, 10'((2 * int'(s1) + 3) & ~3));
      check(10'(size_ok), 10'(t <= int'(BBC_STR_BYTE_LIMIT)));
    end
    // I2C mode: config writes ignored, fields follow straps or fixed values
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys);
      i2c_mode <= 1'b1;
      strap_res <= 2'($urandom);
      strap_en <= j[0];
      host.xfer(1'b1, BBC_OFS_CONFIG, 8'h3E);
      repeat (4) @(posedge clk_sys);
      rd(BBC_OFS_CONFIG, {BBC_I2C_CONN_PWR, strap_res, 1'b0, strap_en});
      #1;
      check(10'({cfg_res, conn}), 10'({strap_res, strap_en}));
      check(10'({pwr, no_pwr}), 10'({BBC_I2C_CONN_PWR, 1'b1}));
      check(10'(fail_info), 10'h000);
    end
    for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge clk_sys);
    if (exp_q.size() != 0) err_total++;
    end_of_test();
  end
endmodule
